// ==== rtl/ccsb_cfg.svh ====
// Register offsets, field positions and reset values of the control register bank
`ifndef CCSB_CFG_SVH
`define CCSB_CFG_SVH
// Offsets are word indices; the APB byte address is four times the index
`define CCSB_OFF_DPH_BYTE     12'h083
`define CCSB_OFF_CMP_LOW      12'h084
`define CCSB_OFF_CMP_HIGH     12'h085
`define CCSB_OFF_P0_OPTION    12'h086
`define CCSB_OFF_POWER        12'h087
`define CCSB_OFF_TIMER_IRQ    12'h088
`define CCSB_OFF_IRQ_STATUS   12'h090
`define CCSB_OFF_IRQ_MASK     12'h094
`define CCSB_OFF_EVENT_IN     12'h098
`define CCSB_RST_BYTE         8'h00
`define CCSB_RST_POWER        8'h10
`define CCSB_PWR_BAUD_DOUBLE  7
`define CCSB_PWR_FE_SELECT    6
`define CCSB_PWR_POR          4
`define CCSB_PWR_USER1        3
`define CCSB_PWR_USER0        2
`define CCSB_PWR_PD           1
`define CCSB_PWR_IDLE         0
`define CCSB_TC_TF1           7
`define CCSB_TC_TR1           6
`define CCSB_TC_TF0           5
`define CCSB_TC_TR0           4
`define CCSB_TC_IE1           3
`define CCSB_TC_IT1           2
`define CCSB_TC_IE0           1
`define CCSB_TC_IT0           0
`define CCSB_IRQ_W            4
`endif

// ==== rtl/ccsb_core_control.sv ====
// APB register bank for data pointer high, comparator base, port 0 option, power and timer control
`timescale 1ns/1ps
`include "ccsb_cfg.svh"

// Summary of operation
// - A read/write byte holds bits 15 to 8 of the data pointer.
// - A read/write byte holds the high byte of the pin 4.0 comparator base address.
// - A read/write byte holds the low byte of the pin 4.0 comparator base address.
// - Option bit 0 clear makes port 0 open-drain, set gives it pull-ups.
// - Power bit 7 set doubles the serial baud rate in serial modes 1, 2 and 3.
// - Power bit 6 selects mode-select bit or framing error status at serial control bit 7.
// - Power bit 4 is set by power-on reset and stays set until software clears it; bit 5 reserved.
// - Power bits 3 and 2 are plain user flags with no hardware effect.
// - Writing 1 to power bit 1 enters power-down, stopping every clock.
// - Writing 1 to power bit 0 enters idle, stopping only the CPU clock.
// - Timer overflow flags set on overflow, clear on vectoring, and are software writable.
// - Timer control bits 6 and 4 switch timer 1 and timer 0 on or off.
// - External interrupt flags set when the configured edge or level appears on the pin.
// - Edge flags clear on vectoring; in level mode the flag tracks the inverted pin.
module ccsb_core_control (
    // Clock and reset
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_POR,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Event sources
    input  wire logic        I_TIMER0_OVERFLOW,
    input  wire logic        I_TIMER1_OVERFLOW,
    input  wire logic        I_TIMER0_VECTORED,
    input  wire logic        I_TIMER1_VECTORED,
    input  wire logic        I_EXT_IRQ0_VECTORED,
    input  wire logic        I_EXT_IRQ1_VECTORED,
    input  wire logic        I_EXT_IRQ0_PIN_N,
    input  wire logic        I_EXT_IRQ1_PIN_N,
    input  wire logic        I_WAKE,
    // Control outputs
    output logic      [15:8] O_DATA_POINTER_HIGH,
    output logic      [15:0] O_PIN_COMPARE_BASE,
    output logic             O_PORT0_PULLUP_ENABLE,
    output logic             O_BAUD_DOUBLE,
    output logic             O_FRAME_ERROR_SELECT,
    output logic             O_CPU_CLK_EN,
    output logic             O_PERIPH_CLK_EN,
    output logic             O_TIMER0_RUN,
    output logic             O_TIMER1_RUN,
    output logic             O_EXT_IRQ0_FLAG,
    output logic             O_EXT_IRQ1_FLAG,
    output logic             O_TIMER0_OVERFLOW_FLAG,
    output logic             O_TIMER1_OVERFLOW_FLAG,
    output logic             O_IRQ
);

    logic [7:0]                  dph_q;
    logic [7:0]                  cmp_low_q;
    logic [7:0]                  cmp_high_q;
    logic                        p0_pullup_q;
    logic [7:0]                  power_q;
    logic [7:0]                  timer_interrupt_control_q;
    logic [`CCSB_IRQ_W-1:0]      irq_status_q;
    logic [`CCSB_IRQ_W-1:0]      irq_mask_q;
    logic [1:0]                  pin0_sync_q;
    logic [1:0]                  pin1_sync_q;
    logic                        pin0_prev_q;
    logic                        pin1_prev_q;
    logic [1:0]                  por_sync_q;
    logic                        por_prev_q;
    ccsb_pkg::ccsb_pwr_state_t   pwr_state_q;
    logic                        wr_en;
    logic                        rd_hit;
    logic [7:0]                  wbyte;
    logic                        fall0;
    logic                        fall1;
    logic                        por_rise;
    logic [`CCSB_IRQ_W-1:0]      irq_events;
    logic [31:0]                 rdata_d;

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
        // Byte address is four times the register index, so no two registers share a word
        addr_is = (a[11:2] == off[9:0]);
    endfunction : addr_is

    assign wr_en  = I_PSEL && I_PENABLE && I_PWRITE;
    assign wbyte  = I_PWDATA[7:0];
    assign fall0  = pin0_prev_q && !pin0_sync_q[1];
    assign fall1  = pin1_prev_q && !pin1_sync_q[1];
    assign por_rise = por_sync_q[1] && !por_prev_q;

    // Pin synchronisers
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            pin0_sync_q <= 2'h3;
            pin1_sync_q <= 2'h3;
            pin0_prev_q <= 1'b1;
            pin1_prev_q <= 1'b1;
            por_sync_q  <= 2'h0;
            por_prev_q  <= 1'b0;
        end else begin
            pin0_sync_q <= {pin0_sync_q[0], I_EXT_IRQ0_PIN_N};
            pin1_sync_q <= {pin1_sync_q[0], I_EXT_IRQ1_PIN_N};
            pin0_prev_q <= pin0_sync_q[1];
            pin1_prev_q <= pin1_sync_q[1];
            por_sync_q  <= {por_sync_q[0], I_POR};
            por_prev_q  <= por_sync_q[1];
        end
    end

    // Plain byte registers
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            dph_q       <= `CCSB_RST_BYTE;
            cmp_low_q   <= `CCSB_RST_BYTE;
            cmp_high_q  <= `CCSB_RST_BYTE;
            p0_pullup_q <= 1'b0;
        end else if (wr_en) begin
            if (addr_is(I_PADDR, `CCSB_OFF_DPH_BYTE)) begin
                dph_q <= wbyte;
            end else if (addr_is(I_PADDR, `CCSB_OFF_CMP_LOW)) begin
                cmp_low_q <= wbyte;
            end else if (addr_is(I_PADDR, `CCSB_OFF_CMP_HIGH)) begin
                cmp_high_q <= wbyte;
            end else if (addr_is(I_PADDR, `CCSB_OFF_P0_OPTION)) begin
                p0_pullup_q <= wbyte[0];
            end
        end
    end

    // Power control; POR flag set wins over software clear
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            power_q <= `CCSB_RST_POWER;
        end else begin
            if (wr_en && addr_is(I_PADDR, `CCSB_OFF_POWER)) begin
                power_q[`CCSB_PWR_BAUD_DOUBLE] <= wbyte[`CCSB_PWR_BAUD_DOUBLE];
                power_q[`CCSB_PWR_FE_SELECT]   <= wbyte[`CCSB_PWR_FE_SELECT];
                power_q[`CCSB_PWR_POR]         <= wbyte[`CCSB_PWR_POR] | por_rise;
                power_q[`CCSB_PWR_USER1]       <= wbyte[`CCSB_PWR_USER1];
                power_q[`CCSB_PWR_USER0]       <= wbyte[`CCSB_PWR_USER0];
                power_q[`CCSB_PWR_PD]          <= wbyte[`CCSB_PWR_PD];
                power_q[`CCSB_PWR_IDLE]        <= wbyte[`CCSB_PWR_IDLE];
            end else begin
                if (por_rise) begin
                    power_q[`CCSB_PWR_POR] <= 1'b1;
                end
                if (I_WAKE) begin
                    power_q[`CCSB_PWR_PD]   <= 1'b0;
                    power_q[`CCSB_PWR_IDLE] <= 1'b0;
                end
            end
        end
    end

    // Power mode; power-down takes priority over idle
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            pwr_state_q <= ccsb_pkg::CCSB_PWR_RUN;
        end else begin
            case (pwr_state_q)
                ccsb_pkg::CCSB_PWR_RUN: begin
                    if (power_q[`CCSB_PWR_PD]) begin
                        pwr_state_q <= ccsb_pkg::CCSB_PWR_DOWN_MODE;
                    end else if (power_q[`CCSB_PWR_IDLE]) begin
                        pwr_state_q <= ccsb_pkg::CCSB_PWR_IDLE_MODE;
                    end
                end
                default: begin
                    if (I_WAKE) begin
                        pwr_state_q <= ccsb_pkg::CCSB_PWR_RUN;
                    end
                end
            endcase
        end
    end

    // Timer and external interrupt control; hardware set wins over clear
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            timer_interrupt_control_q <= `CCSB_RST_BYTE;
        end else begin
            if (wr_en && addr_is(I_PADDR, `CCSB_OFF_TIMER_IRQ)) begin
                timer_interrupt_control_q <= wbyte;
            end else begin
                if (I_TIMER1_VECTORED) begin
                    timer_interrupt_control_q[`CCSB_TC_TF1] <= 1'b0;
                end
                if (I_TIMER0_VECTORED) begin
                    timer_interrupt_control_q[`CCSB_TC_TF0] <= 1'b0;
                end
                if (timer_interrupt_control_q[`CCSB_TC_IT1] && I_EXT_IRQ1_VECTORED) begin
                    timer_interrupt_control_q[`CCSB_TC_IE1] <= 1'b0;
                end
                if (timer_interrupt_control_q[`CCSB_TC_IT0] && I_EXT_IRQ0_VECTORED) begin
                    timer_interrupt_control_q[`CCSB_TC_IE0] <= 1'b0;
                end
            end
            if (I_TIMER1_OVERFLOW) begin
                timer_interrupt_control_q[`CCSB_TC_TF1] <= 1'b1;
            end
            if (I_TIMER0_OVERFLOW) begin
                timer_interrupt_control_q[`CCSB_TC_TF0] <= 1'b1;
            end
            if (timer_interrupt_control_q[`CCSB_TC_IT1]) begin
                if (fall1) begin
                    timer_interrupt_control_q[`CCSB_TC_IE1] <= 1'b1;
                end
            end else begin
                timer_interrupt_control_q[`CCSB_TC_IE1] <= !pin1_sync_q[1];
            end
            if (timer_interrupt_control_q[`CCSB_TC_IT0]) begin
                if (fall0) begin
                    timer_interrupt_control_q[`CCSB_TC_IE0] <= 1'b1;
                end
            end else begin
                timer_interrupt_control_q[`CCSB_TC_IE0] <= !pin0_sync_q[1];
            end
        end
    end

    // Sticky event status: timer0, timer1, ext0, ext1 overflow/edge
    assign irq_events = {fall1, fall0, I_TIMER1_OVERFLOW, I_TIMER0_OVERFLOW};

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            irq_status_q <= '0;
        end else if (wr_en && addr_is(I_PADDR, `CCSB_OFF_IRQ_STATUS)) begin
            irq_status_q <= (irq_status_q & ~I_PWDATA[`CCSB_IRQ_W-1:0]) | irq_events;
        end else begin
            irq_status_q <= irq_status_q | irq_events;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            irq_mask_q <= '0;
        end else if (wr_en && addr_is(I_PADDR, `CCSB_OFF_IRQ_MASK)) begin
            irq_mask_q <= I_PWDATA[`CCSB_IRQ_W-1:0];
        end
    end

    // Read mux
    always_comb begin
        rd_hit  = 1'b1;
        rdata_d = 32'h0000_0000;
        if (addr_is(I_PADDR, `CCSB_OFF_DPH_BYTE)) begin
            rdata_d[7:0] = dph_q;
        end else if (addr_is(I_PADDR, `CCSB_OFF_CMP_LOW)) begin
            rdata_d[7:0] = cmp_low_q;
        end else if (addr_is(I_PADDR, `CCSB_OFF_CMP_HIGH)) begin
            rdata_d[7:0] = cmp_high_q;
        end else if (addr_is(I_PADDR, `CCSB_OFF_P0_OPTION)) begin
            rdata_d[0] = p0_pullup_q;
        end else if (addr_is(I_PADDR, `CCSB_OFF_POWER)) begin
            rdata_d[7:0] = power_q & 8'hdf;
        end else if (addr_is(I_PADDR, `CCSB_OFF_TIMER_IRQ)) begin
            rdata_d[7:0] = timer_interrupt_control_q;
        end else if (addr_is(I_PADDR, `CCSB_OFF_IRQ_STATUS)) begin
            rdata_d[`CCSB_IRQ_W-1:0] = irq_status_q;
        end else if (addr_is(I_PADDR, `CCSB_OFF_IRQ_MASK)) begin
            rdata_d[`CCSB_IRQ_W-1:0] = irq_mask_q;
        end else if (addr_is(I_PADDR, `CCSB_OFF_EVENT_IN)) begin
            rdata_d[1:0] = {pin1_sync_q[1], pin0_sync_q[1]};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            O_PRDATA <= 32'h0000_0000;
        end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            O_PRDATA <= rdata_d;
        end
    end

    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = I_PSEL && I_PENABLE && !rd_hit;

    assign O_DATA_POINTER_HIGH    = dph_q;
    assign O_PIN_COMPARE_BASE     = {cmp_high_q, cmp_low_q};
    assign O_PORT0_PULLUP_ENABLE  = p0_pullup_q;
    assign O_BAUD_DOUBLE          = power_q[`CCSB_PWR_BAUD_DOUBLE];
    assign O_FRAME_ERROR_SELECT   = power_q[`CCSB_PWR_FE_SELECT];
    assign O_CPU_CLK_EN           = (pwr_state_q == ccsb_pkg::CCSB_PWR_RUN);
    assign O_PERIPH_CLK_EN        = (pwr_state_q != ccsb_pkg::CCSB_PWR_DOWN_MODE);
    assign O_TIMER0_RUN           = timer_interrupt_control_q[`CCSB_TC_TR0];
    assign O_TIMER1_RUN           = timer_interrupt_control_q[`CCSB_TC_TR1];
    assign O_EXT_IRQ0_FLAG        = timer_interrupt_control_q[`CCSB_TC_IE0];
    assign O_EXT_IRQ1_FLAG        = timer_interrupt_control_q[`CCSB_TC_IE1];
    assign O_TIMER0_OVERFLOW_FLAG = timer_interrupt_control_q[`CCSB_TC_TF0];
    assign O_TIMER1_OVERFLOW_FLAG = timer_interrupt_control_q[`CCSB_TC_TF1];
    assign O_IRQ                  = |(irq_status_q & irq_mask_q);

endmodule : ccsb_core_control

// ==== rtl/ccsb_pkg.sv ====
// Types shared by the control register bank
package ccsb_pkg;
    typedef enum logic [1:0] {
        CCSB_PWR_RUN,
        CCSB_PWR_IDLE_MODE,
        CCSB_PWR_DOWN_MODE
    } ccsb_pwr_state_t;
endpackage : ccsb_pkg

// ==== sim/ccsb_core_control_assertions.sv ====
// Concurrent checks on the control register bank ports
`timescale 1ns/1ps
`include "ccsb_cfg.svh"
module ccsb_core_control_chk (
    // Clock, reset and bus
    input wire logic        I_CORE_CLK, I_RST, I_PSEL, I_PENABLE, I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    // Events and pins
    input wire logic        I_TIMER0_OVERFLOW, I_TIMER0_VECTORED, I_EXT_IRQ0_PIN_N, I_EXT_IRQ1_PIN_N,
    // Control outputs
    input wire logic [15:8] O_DATA_POINTER_HIGH,
    input wire logic [15:0] O_PIN_COMPARE_BASE,
    input wire logic        O_PORT0_PULLUP_ENABLE, O_BAUD_DOUBLE, O_FRAME_ERROR_SELECT,
    input wire logic        O_CPU_CLK_EN, O_PERIPH_CLK_EN, O_TIMER0_RUN, O_TIMER1_RUN,
    input wire logic        O_EXT_IRQ0_FLAG, O_EXT_IRQ1_FLAG, O_TIMER0_OVERFLOW_FLAG
);
    localparam logic [11:0] A_DPH  = 12'(`CCSB_OFF_DPH_BYTE * 4);
    localparam logic [11:0] A_HIGH = 12'(`CCSB_OFF_CMP_HIGH * 4);
    localparam logic [11:0] A_P0   = 12'(`CCSB_OFF_P0_OPTION * 4);
    localparam logic [11:0] A_PWR  = 12'(`CCSB_OFF_POWER * 4);
    localparam logic [11:0] A_TC   = 12'(`CCSB_OFF_TIMER_IRQ * 4);
    logic wr;
    logic it0_q;
    logic it1_q;
    assign wr = I_PSEL && I_PENABLE && I_PWRITE;
    // Trigger types as last written by software
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            it0_q <= 1'b0;
            it1_q <= 1'b0;
        end else if (wr && I_PADDR == A_TC) begin
            it0_q <= I_PWDATA[0];
            it1_q <= I_PWDATA[2];
        end
    end
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    property p_dph; wr && I_PADDR == A_DPH |=> O_DATA_POINTER_HIGH == $past(I_PWDATA[7:0]); endproperty
    a_dph: assert property (p_dph) else $error("data pointer high not written");
    property p_cmp; wr && I_PADDR == A_HIGH |=> O_PIN_COMPARE_BASE[15:8] == $past(I_PWDATA[7:0]);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare base high not written");
    property p_pup; wr && I_PADDR == A_P0 |=> O_PORT0_PULLUP_ENABLE == $past(I_PWDATA[0]); endproperty
    a_pup: assert property (p_pup) else $error("pull-up option not written");
    property p_baud; wr && I_PADDR == A_PWR |=>
        {O_BAUD_DOUBLE, O_FRAME_ERROR_SELECT} == $past(I_PWDATA[7:6]); endproperty
    a_baud: assert property (p_baud) else $error("baud or frame select wrong");
    property p_run; wr && I_PADDR == A_TC |=>
        {O_TIMER1_RUN, O_TIMER0_RUN} == {$past(I_PWDATA[6]), $past(I_PWDATA[4])}; endproperty
    a_run: assert property (p_run) else $error("timer run bits wrong");
    property p_ovf; I_TIMER0_OVERFLOW |=> O_TIMER0_OVERFLOW_FLAG; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow did not set flag");
    property p_vec; I_TIMER0_VECTORED && !I_TIMER0_OVERFLOW && !(wr && I_PADDR == A_TC)
        |=> !O_TIMER0_OVERFLOW_FLAG; endproperty
    a_vec: assert property (p_vec) else $error("vectoring did not clear flag");
    property p_edge; it0_q && $fell(I_EXT_IRQ0_PIN_N) |-> ##[1:5] O_EXT_IRQ0_FLAG; endproperty
    a_edge: assert property (p_edge) else $error("falling edge not flagged");
    property p_level; (!it1_q && !I_EXT_IRQ1_PIN_N) [*4] |-> O_EXT_IRQ1_FLAG; endproperty
    a_level: assert property (p_level) else $error("low level not flagged");
    property p_pdown; wr && I_PADDR == A_PWR && I_PWDATA[1] |-> ##[1:3]
        (!O_PERIPH_CLK_EN && !O_CPU_CLK_EN); endproperty
    a_pdown: assert property (p_pdown) else $error("power-down not entered");
    property p_idle; wr && I_PADDR == A_PWR && I_PWDATA[1:0] == 2'h1 |-> ##[1:3]
        (!O_CPU_CLK_EN && O_PERIPH_CLK_EN); endproperty
    a_idle: assert property (p_idle) else $error("idle not entered");
endmodule : ccsb_core_control_chk

bind ccsb_core_control ccsb_core_control_chk u_chk (.*);

// ==== sim/ccsb_core_control_tb.sv ====
// Self-checking bench for the control register bank
`timescale 1ns/1ps
`include "ccsb_cfg.svh"
module ccsb_core_control_tb;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic [31:0] r;} ccsb_row_t;
    localparam logic [11:0] A_PWR = 12'(`CCSB_OFF_POWER * 4);
    localparam logic [11:0] A_TC  = 12'(`CCSB_OFF_TIMER_IRQ * 4);
    localparam logic [11:0] A_STS = 12'(`CCSB_OFF_IRQ_STATUS * 4);
    localparam logic [11:0] A_MSK = 12'(`CCSB_OFF_IRQ_MASK * 4);
    ccsb_row_t rows [6] = '{
        '{12'(`CCSB_OFF_DPH_BYTE * 4), 32'h1234_56a5, 32'ha5, 32'h00},
        '{12'(`CCSB_OFF_CMP_LOW * 4), 32'h3c, 32'h3c, 32'h00},
        '{12'(`CCSB_OFF_CMP_HIGH * 4), 32'hc3, 32'hc3, 32'h00},
        '{12'(`CCSB_OFF_P0_OPTION * 4), 32'hff, 32'h01, 32'h00},
        '{A_PWR, 32'hec, 32'hcc, 32'h10},
        '{A_TC, 32'h50, 32'h50, 32'h00}};
    logic        clk = 1'b0, rst = 1'b1, por = 1'b0, pin0_n = 1'b1, pin1_n = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [6:0]  ev = 7'h00;
    logic [15:8] data_pointer_high;
    logic [15:0] cmpb;
    logic        pup, baud, fes, cpu_en, per_en, run0, run1, x0f, x1f, t0f, t1f, irq;
    int          n_errors = 0, check_count = 0, cyc = 0;
    ccsb_core_control u_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_POR(por), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_TIMER0_OVERFLOW(ev[0]), .I_TIMER1_OVERFLOW(ev[1]), .I_TIMER0_VECTORED(ev[2]),
        .I_TIMER1_VECTORED(ev[3]), .I_EXT_IRQ0_VECTORED(ev[4]), .I_EXT_IRQ1_VECTORED(ev[5]),
        .I_EXT_IRQ0_PIN_N(pin0_n), .I_EXT_IRQ1_PIN_N(pin1_n), .I_WAKE(ev[6]),
        .O_DATA_POINTER_HIGH(data_pointer_high), .O_PIN_COMPARE_BASE(cmpb), .O_PORT0_PULLUP_ENABLE(pup),
        .O_BAUD_DOUBLE(baud), .O_FRAME_ERROR_SELECT(fes), .O_CPU_CLK_EN(cpu_en),
        .O_PERIPH_CLK_EN(per_en), .O_TIMER0_RUN(run0), .O_TIMER1_RUN(run1),
        .O_EXT_IRQ0_FLAG(x0f), .O_EXT_IRQ1_FLAG(x1f), .O_TIMER0_OVERFLOW_FLAG(t0f),
        .O_TIMER1_OVERFLOW_FLAG(t1f), .O_IRQ(irq));
    always #50 clk = ~clk;
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            $display("[FAIL] %0t timeout", $time);
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask : rd
    task automatic pulse(input logic [6:0] m);
        @(posedge clk) ev <= m;
        @(posedge clk) ev <= 7'h00;
        @(negedge clk);
    endtask : pulse
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : hold
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) rd(rows[i].a, rows[i].r);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].q);
        end
        hold(1);
        chk(32'(data_pointer_high), 32'ha5);
        chk(32'(cmpb), 32'hc33c);
        chk(32'({pup, baud, fes, run1, run0}), 32'h1f);
        pulse(7'h03);
        chk(32'({t1f, t0f, irq}), 32'h6);
        rd(A_STS, 32'h3);
        apb(1'b1, A_MSK, 32'h2);
        hold(1);
        chk(32'(irq), 32'h1);
        apb(1'b1, A_STS, 32'h2);
        hold(1);
        chk(32'(irq), 32'h0);
        rd(A_STS, 32'h1);
        pulse(7'h0c);
        chk(32'({t1f, t0f}), 32'h0);
        apb(1'b1, A_TC, 32'hf0);
        rd(A_TC, 32'hf0);
        apb(1'b1, A_TC, 32'h51);
        @(posedge clk) pin0_n <= 1'b0;
        hold(5);
        chk(32'(x0f), 32'h1);
        pulse(7'h10);
        hold(4);
        chk(32'(x0f), 32'h0);
        @(posedge clk) pin0_n <= 1'b1;
        apb(1'b1, A_TC, 32'h50);
        @(posedge clk) pin1_n <= 1'b0;
        hold(5);
        chk(32'(x1f), 32'h1);
        pulse(7'h20);
        chk(32'(x1f), 32'h1);
        @(posedge clk) pin1_n <= 1'b1;
        hold(5);
        chk(32'(x1f), 32'h0);
        apb(1'b1, A_PWR, 32'h01);
        hold(3);
        chk(32'({cpu_en, per_en}), 32'h1);
        pulse(7'h40);
        hold(3);
        chk(32'({cpu_en, per_en}), 32'h3);
        apb(1'b1, A_PWR, 32'h02);
        hold(3);
        chk(32'({cpu_en, per_en}), 32'h0);
        pulse(7'h40);
        hold(3);
        rd(A_PWR, 32'h00);
        @(posedge clk) por <= 1'b1;
        hold(4);
        rd(A_PWR, 32'h10);
        por <= 1'b0;
        apb(1'b1, 12'h300, 32'hff);
        chk(32'(err), 32'h1);
        rd(12'h300, 32'h0);
        chk(32'(err), 32'h1);
        end_sim();
    end
endmodule : ccsb_core_control_tb
